// ===== logic/tws_pkg.sv
// shared constants for the two-wire slave interface
package tws_pkg;
    // =========================================================
    // register byte addresses
    localparam logic [7:0] ADDR_OWN   = 8'h00;
    localparam logic [7:0] ADDR_CTRL0 = 8'h04;
    localparam logic [7:0] ADDR_CTRL1 = 8'h08;
    localparam logic [7:0] ADDR_DATA  = 8'h0C;
    // =========================================================
    // serial_control_zero fields
    localparam int CTL0_EN_BIT  = 0;
    localparam int CTL0_MODE_LO = 1;
    localparam int CTL0_DB_LO   = 4;
    localparam int CTL0_IRQ_BIT = 6;
    localparam logic [2:0] MODE_TWO_WIRE = 3'h6;
    // =========================================================
    // serial_control_one fields
    localparam int CTL1_RX_ACK_FLAG = 0;
    localparam int CTL1_SRW  = 2;
    localparam int CTL1_TX_ACK_LEVEL_BIT = 3;
    localparam int CTL1_HTX  = 4;
    localparam int CTL1_HBB  = 5;
    localparam int CTL1_ADDRESS_MATCH_FLAG = 6;
    localparam int CTL1_HCF  = 7;
    // =========================================================
    // reset values
    localparam logic [7:0] RST_OWN   = 8'h00;
    localparam logic [6:0] RST_CTRL0 = 7'h00;
    localparam logic [7:0] RST_DATA  = 8'h00;
    // =========================================================
    // debounce selections, in system clocks
    localparam logic [1:0] DB_NONE = 2'h0;
    localparam logic [1:0] DB_ONE  = 2'h1;
    localparam logic [1:0] DB_TWO  = 2'h2;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    // =========================================================
    // slave state machine
    typedef enum logic [8:0] {
        S_IDLE  = 9'h001,
        S_ADDR  = 9'h002,
        S_AACK  = 9'h004,
        S_HOLD  = 9'h008,
        S_RXB   = 9'h010,
        S_RXACK = 9'h020,
        S_TXB   = 9'h040,
        S_TXACK = 9'h080,
        S_WAITP = 9'h100
    } tws_state_e;
endpackage

// ===== logic/tws_line_filter.sv
// two-flop synchroniser with optional 1 or 2 clock glitch filter
`timescale 1ns/1ns
module tws_line_filter (
    input  wire logic       i_clk,
    input  wire logic       i_rst_n,
    input  wire logic       i_line,
    input  wire logic [1:0] i_db_sel,
    output logic            o_line
);
    logic meta_q;
    logic sync_q;
    logic [1:0] hist_q;
    logic stable;

    // =========================================================
    // synchroniser; idle bus level is high
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            meta_q <= 1'b1;
            sync_q <= 1'b1;
            hist_q <= 2'h3;
        end else begin
            meta_q <= i_line;
            sync_q <= meta_q;
            hist_q <= {hist_q[0], sync_q};
        end
    end

    // level must hold for the chosen number of extra clocks
    always_comb begin
        case (i_db_sel)
            tws_pkg::DB_ONE: stable = (sync_q == hist_q[0]);
            tws_pkg::DB_TWO: stable = (sync_q == hist_q[0]) && (sync_q == hist_q[1]);
            default:         stable = 1'b1;
        endcase
    end

    // =========================================================
    // filtered output only follows a stable level
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_line <= 1'b1;
        end else if (stable) begin
            o_line <= sync_q;
        end
    end
endmodule // tws_line_filter

// ===== logic/tws_slave.sv
// two-wire slave interface with APB register access
// What this block does
// - own 7-bit address sits in bits 7..1; bit 0 ignored in compare
// - address match sets match flag and raises interrupt; mismatch leaves it low
// - eighth bit after address is stored as slave read/write flag
// - on match, SDA held low during ninth clock as acknowledge
// - START is SDA falling with SCL high; sets bus busy flag
// - device is slave only and never makes a START
// - one interrupt for address match and byte done; match flag tells which
// - after match SCL held low until data write or dummy data read
// - transmit role bit: 1 transmits, 0 receives, set by software
// - data bytes are 8 bits, MSB first, after address acknowledge
// - as receiver, tx ack level bit driven on SDA at ninth clock
// - as transmitter, ack sampled into rx ack flag; no ack releases SDA
// - received bytes land in data register; loaded byte is transmitted
// - two-wire slave mode only when mode field is 110
// - STOP clears the bus busy flag
// - transfer complete flag low during byte, high with interrupt at end
// - optional line debounce of none, 1 or 2 system clocks
//
// The implementer's own choices: register access over APB and the placing of the registers.
`timescale 1ns/1ns
module tws_slave (
    input  wire logic        I_CORE_CLK,
    input  wire logic        I_RST_N,
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [7:0]  PADDR,
    input  wire logic [31:0] PWDATA,
    output logic [31:0]      PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    input  wire logic        I_SCL,
    output logic             O_SCL,
    output logic             O_SCL_OE,
    input  wire logic        I_SDA,
    output logic             O_SDA,
    output logic             O_SDA_OE,
    output logic             O_IRQ
);
    logic [7:0] own_q;
    logic [6:0] ctrl0_q;
    logic [7:0] data_q;
    logic       htx_q;
    logic       tx_ack_level_bit_q;
    logic       srw_q;
    logic       rx_ack_flag_q;
    logic       hbb_q;
    logic       address_match_flag_q;
    logic       hcf_q;
    tws_pkg::tws_state_e state_q;
    logic [7:0] shift_q;
    logic [3:0] cnt_q;
    logic       scl_f;
    logic       sda_f;
    logic       scl_p_q;
    logic       sda_p_q;
    logic       active;
    logic       scl_rise;
    logic       scl_fall;
    logic       start_c;
    logic       stop_c;
    logic       setup_c;
    logic       acc_c;
    logic       wr_data;
    logic       rd_data;
    logic       irq_ev;
    logic       done_c;

    // =========================================================
    // line conditioning
    tws_line_filter u_scl_filt (
        .i_clk    (I_CORE_CLK),
        .i_rst_n  (I_RST_N),
        .i_line   (I_SCL),
        .i_db_sel (ctrl0_q[tws_pkg::CTL0_DB_LO +: 2]),
        .o_line   (scl_f)
    );

    tws_line_filter u_sda_filt (
        .i_clk    (I_CORE_CLK),
        .i_rst_n  (I_RST_N),
        .i_line   (I_SDA),
        .i_db_sel (ctrl0_q[tws_pkg::CTL0_DB_LO +: 2]),
        .o_line   (sda_f)
    );

    // previous filtered levels for edge finding
    always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            scl_p_q <= 1'b1;
            sda_p_q <= 1'b1;
        end else begin
            scl_p_q <= scl_f;
            sda_p_q <= sda_f;
        end
    end

    // enable and mode gate all bus activity
    assign active   = ctrl0_q[tws_pkg::CTL0_EN_BIT]
                    && (ctrl0_q[tws_pkg::CTL0_MODE_LO +: 3] == tws_pkg::MODE_TWO_WIRE);
    assign scl_rise = active && scl_f && !scl_p_q;
    assign scl_fall = active && !scl_f && scl_p_q;
    assign start_c  = active && scl_f && scl_p_q && sda_p_q && !sda_f;
    assign stop_c   = active && scl_f && scl_p_q && !sda_p_q && sda_f;
    assign done_c   = (cnt_q == tws_pkg::BITS_PER_BYTE);

    // =========================================================
    // APB slave, zero wait states, pready from a flop
    assign setup_c = PSEL && !PENABLE;
    assign acc_c   = PSEL && PENABLE && PREADY;
    assign wr_data = acc_c && PWRITE && (PADDR == tws_pkg::ADDR_DATA);
    assign rd_data = acc_c && !PWRITE && (PADDR == tws_pkg::ADDR_DATA);

    function automatic logic mapped(input logic [7:0] a);
        mapped = (a == tws_pkg::ADDR_OWN) || (a == tws_pkg::ADDR_CTRL0)
              || (a == tws_pkg::ADDR_CTRL1) || (a == tws_pkg::ADDR_DATA);
    endfunction

    // read data captured in the setup cycle
    always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            PREADY  <= 1'b0;
            PSLVERR <= 1'b0;
            PRDATA  <= 32'h0000_0000;
        end else begin
            PREADY  <= setup_c;
            PSLVERR <= setup_c && !mapped(PADDR);
            if (setup_c && !PWRITE) begin
                case (PADDR)
                    tws_pkg::ADDR_OWN:   PRDATA <= {24'h000000, own_q[7:1], 1'b0};
                    tws_pkg::ADDR_CTRL0: PRDATA <= {25'h0, ctrl0_q};
                    tws_pkg::ADDR_CTRL1: PRDATA <= {24'h000000, hcf_q, address_match_flag_q, hbb_q,
                                                    htx_q, tx_ack_level_bit_q, srw_q, 1'b0, rx_ack_flag_q};
                    tws_pkg::ADDR_DATA:  PRDATA <= {24'h000000, data_q};
                    default:             PRDATA <= 32'h0000_0000;
                endcase
            end
        end
    end

    // software controlled registers
    always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            own_q   <= tws_pkg::RST_OWN;
            ctrl0_q <= tws_pkg::RST_CTRL0;
            htx_q   <= 1'b0;
            tx_ack_level_bit_q  <= 1'b0;
        end else if (acc_c && PWRITE) begin
            if (PADDR == tws_pkg::ADDR_OWN) begin
                own_q <= PWDATA[7:0];
            end
            if (PADDR == tws_pkg::ADDR_CTRL0) begin
                ctrl0_q <= PWDATA[6:0];
            end
            if (PADDR == tws_pkg::ADDR_CTRL1) begin
                htx_q  <= PWDATA[tws_pkg::CTL1_HTX];
                tx_ack_level_bit_q <= PWDATA[tws_pkg::CTL1_TX_ACK_LEVEL_BIT];
            end
        end
    end

    // data register: bus byte wins over a software write
    always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            data_q <= tws_pkg::RST_DATA;
        end else if (state_q == tws_pkg::S_RXB && scl_fall && done_c) begin
            data_q <= shift_q;
        end else if (wr_data) begin
            data_q <= PWDATA[7:0];
        end
    end

    // =========================================================
    // bus busy follows START and STOP
    always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            hbb_q <= 1'b0;
        end else if (!active || stop_c) begin
            hbb_q <= 1'b0;
        end else if (start_c) begin
            hbb_q <= 1'b1;
        end
    end

    // =========================================================
    // slave sequencer; only ever answers, never starts
    always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            state_q  <= tws_pkg::S_IDLE;
            shift_q  <= 8'h00;
            cnt_q    <= 4'h0;
            O_SDA_OE <= 1'b0;
            O_SCL_OE <= 1'b0;
        end else if (!active || stop_c) begin
            state_q  <= tws_pkg::S_IDLE;
            O_SDA_OE <= 1'b0;
            O_SCL_OE <= 1'b0;
        end else if (start_c) begin
            state_q  <= tws_pkg::S_ADDR;
            cnt_q    <= 4'h0;
            O_SDA_OE <= 1'b0;
            O_SCL_OE <= 1'b0;
        end else begin
            case (state_q)
                tws_pkg::S_ADDR: begin
                    if (scl_rise) begin
                        shift_q <= {shift_q[6:0], sda_f};
                        cnt_q   <= cnt_q + 4'h1;
                    end else if (scl_fall && done_c) begin
                        cnt_q <= 4'h0;
                        if (shift_q[7:1] == own_q[7:1]) begin
                            O_SDA_OE <= 1'b1;
                            state_q  <= tws_pkg::S_AACK;
                        end else begin
                            state_q <= tws_pkg::S_WAITP;
                        end
                    end
                end
                tws_pkg::S_AACK: begin
                    if (scl_fall) begin
                        O_SDA_OE <= 1'b0;
                        O_SCL_OE <= 1'b1;
                        state_q  <= tws_pkg::S_HOLD;
                    end
                end
                tws_pkg::S_HOLD: begin
                    // stretch lasts until software writes (transmitter) or reads (receiver) the data register
                    if (htx_q && wr_data) begin
                        shift_q  <= PWDATA[7:0];
                        O_SDA_OE <= !PWDATA[7];
                        O_SCL_OE <= 1'b0;
                        cnt_q    <= 4'h0;
                        state_q  <= tws_pkg::S_TXB;
                    end else if (!htx_q && rd_data) begin
                        O_SCL_OE <= 1'b0;
                        cnt_q    <= 4'h0;
                        state_q  <= tws_pkg::S_RXB;
                    end
                end
                tws_pkg::S_RXB: begin
                    if (scl_rise) begin
                        shift_q <= {shift_q[6:0], sda_f};
                        cnt_q   <= cnt_q + 4'h1;
                    end else if (scl_fall && done_c) begin
                        O_SDA_OE <= !tx_ack_level_bit_q;
                        state_q  <= tws_pkg::S_RXACK;
                    end
                end
                tws_pkg::S_RXACK: begin
                    if (scl_fall) begin
                        O_SDA_OE <= 1'b0;
                        O_SCL_OE <= 1'b1;
                        state_q  <= tws_pkg::S_HOLD;
                    end
                end
                tws_pkg::S_TXB: begin
                    // next bit is presented as the clock falls
                    if (scl_rise) begin
                        cnt_q <= cnt_q + 4'h1;
                    end else if (scl_fall) begin
                        if (done_c) begin
                            O_SDA_OE <= 1'b0;
                            state_q  <= tws_pkg::S_TXACK;
                        end else begin
                            shift_q  <= {shift_q[6:0], 1'b0};
                            O_SDA_OE <= !shift_q[6];
                        end
                    end
                end
                tws_pkg::S_TXACK: begin
                    if (scl_fall) begin
                        cnt_q <= 4'h0;
                        if (rx_ack_flag_q) begin
                            state_q <= tws_pkg::S_WAITP;
                        end else begin
                            O_SCL_OE <= 1'b1;
                            state_q  <= tws_pkg::S_HOLD;
                        end
                    end
                end
                tws_pkg::S_WAITP: begin
                    O_SDA_OE <= 1'b0;
                    O_SCL_OE <= 1'b0;
                end
                default: begin
                    O_SDA_OE <= 1'b0;
                    O_SCL_OE <= 1'b0;
                end
            endcase
        end
    end

    // the pins only ever pull low
    always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            O_SDA <= 1'b0;
            O_SCL <= 1'b0;
        end else begin
            O_SDA <= 1'b0;
            O_SCL <= 1'b0;
        end
    end

    // =========================================================
    // status flags set by the bus side
    always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            address_match_flag_q <= 1'b0;
            srw_q  <= 1'b0;
            rx_ack_flag_q <= 1'b0;
            hcf_q  <= 1'b1;
        end else if (!active) begin
            address_match_flag_q <= 1'b0;
        end else begin
            if (start_c) begin
                address_match_flag_q <= 1'b0;
            end else if (state_q == tws_pkg::S_ADDR && scl_fall && done_c) begin
                address_match_flag_q <= (shift_q[7:1] == own_q[7:1]);
                if (shift_q[7:1] == own_q[7:1]) begin
                    srw_q <= shift_q[0];
                end
            end else if (hcf_q && state_q != tws_pkg::S_HOLD && state_q != tws_pkg::S_IDLE
                         && state_q != tws_pkg::S_WAITP && state_q != tws_pkg::S_ADDR) begin
                address_match_flag_q <= address_match_flag_q;
            end
            if (state_q == tws_pkg::S_TXACK && scl_rise) begin
                rx_ack_flag_q <= sda_f;
            end
            // low for the whole byte, high once it completes
            if ((state_q == tws_pkg::S_RXACK || state_q == tws_pkg::S_TXACK) && scl_fall) begin
                hcf_q <= 1'b1;
            end else if (state_q == tws_pkg::S_RXB || state_q == tws_pkg::S_TXB) begin
                hcf_q  <= 1'b0;
                address_match_flag_q <= 1'b0; // byte phase, so match flag no longer the cause
            end
        end
    end

    // one request for match or completed byte
    assign irq_ev = (state_q == tws_pkg::S_ADDR && scl_fall && done_c
                     && shift_q[7:1] == own_q[7:1])
                  || ((state_q == tws_pkg::S_RXACK || state_q == tws_pkg::S_TXACK) && scl_fall);

    always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            O_IRQ <= 1'b0;
        end else begin
            O_IRQ <= irq_ev && !start_c && !stop_c && ctrl0_q[tws_pkg::CTL0_IRQ_BIT];
        end
    end
endmodule // tws_slave

// ===== testbench/tws_props.sv
// port-level assertion checker for the two-wire slave
`timescale 1ns/1ns
module tws_props (
    input wire logic        I_CORE_CLK,
    input wire logic        I_RST_N,
    input wire logic        PSEL,
    input wire logic        PENABLE,
    input wire logic        PWRITE,
    input wire logic [7:0]  PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [31:0] PRDATA,
    input wire logic        PREADY,
    input wire logic        I_SCL,
    input wire logic        O_SCL_OE,
    input wire logic        I_SDA,
    input wire logic        O_SDA_OE,
    input wire logic        O_IRQ
);
    // ========================================
    // helpers: enable shadow, pin history, busy seen on the wires
    logic en_q, busy_q, sda_q, scl_q;
    wire acc  = PSEL && PENABLE && PREADY;
    wire rd   = acc && !PWRITE;
    wire dacc = acc && (PADDR == tws_pkg::ADDR_DATA);
    wire stop_ev = scl_q && I_SCL && !sda_q && I_SDA;
    always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            en_q <= 1'b0;
            busy_q <= 1'b0;
            sda_q <= 1'b1;
            scl_q <= 1'b1;
        end else begin
            if (acc && PWRITE && PADDR == tws_pkg::ADDR_CTRL0) begin
                en_q <= PWDATA[0] && (PWDATA[3:1] == tws_pkg::MODE_TWO_WIRE);
            end
            if (scl_q && I_SCL && sda_q != I_SDA) begin
                busy_q <= !I_SDA;
            end
            sda_q <= I_SDA;
            scl_q <= I_SCL;
        end
    end
    default clocking @(posedge I_CORE_CLK); endclocking
    default disable iff (!I_RST_N);
    // ========================================
    // properties
    property p_sda_quiet;
        I_SCL && $past(I_SCL) |-> $stable(O_SDA_OE);
    endproperty
    a_sda_quiet: assert property (p_sda_quiet) else $error("sda drive moved with scl high");
    property p_scl_hold;
        $rose(O_SCL_OE) |-> !I_SCL;
    endproperty
    a_scl_hold: assert property (p_scl_hold) else $error("scl pulled while high");
    property p_irq;
        O_IRQ |-> !I_SCL ##1 !O_IRQ;
    endproperty
    a_irq: assert property (p_irq) else $error("irq not a pulse in scl low");
    property p_release;
        $fell(O_SCL_OE) |-> $past(dacc) || $past(dacc, 2);
    endproperty
    a_release: assert property (p_release) else $error("scl freed without data access");
    property p_off;
        !en_q && !$past(en_q) && !$past(en_q, 2) |-> !O_SDA_OE && !O_SCL_OE && !O_IRQ;
    endproperty
    a_off: assert property (p_off) else $error("activity while disabled");
    property p_busy;
        rd && en_q && PADDR == tws_pkg::ADDR_CTRL1 |-> PRDATA[tws_pkg::CTL1_HBB] == busy_q;
    endproperty
    a_busy: assert property (p_busy) else $error("busy flag wrong");
    property p_own;
        rd && PADDR == tws_pkg::ADDR_OWN |-> PRDATA[0] == 1'b0 && PRDATA[31:8] == 24'h0;
    endproperty
    a_own: assert property (p_own) else $error("own address low bit set");
    property p_stop;
        stop_ev |-> ##6 (!O_SDA_OE && !O_SCL_OE) [*4];
    endproperty
    a_stop: assert property (p_stop) else $error("drive after stop");
    c_irq: cover property (O_IRQ);
    c_release: cover property ($fell(O_SCL_OE));
    c_stop: cover property (stop_ev);
endmodule // tws_props

bind tws_slave tws_props u_props (
    .I_CORE_CLK(I_CORE_CLK), .I_RST_N(I_RST_N), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
    .I_SCL(I_SCL), .O_SCL_OE(O_SCL_OE), .I_SDA(I_SDA), .O_SDA_OE(O_SDA_OE), .O_IRQ(O_IRQ)
);

// ===== testbench/tws_master.sv
// two-wire bus master model, open-drain drive
`timescale 1ns/1ns
module tws_master (
    input  wire logic i_clk,
    input  wire logic i_scl,
    input  wire logic i_sda,
    output logic      o_scl_oe,
    output logic      o_sda_oe
);
    // ========================================
    // quarter of the 80 ns link period, in core clocks
    localparam int Q = 5;
    initial begin
        o_scl_oe = 1'b0;
        o_sda_oe = 1'b0;
    end
    task automatic wt(input int n);
        repeat (n) @(posedge i_clk);
    endtask
    // one bit; waits out stretching, so slave holds never get cut short
    task automatic bit_x(input logic b, output logic r);
        o_sda_oe <= !b;
        wt(Q);
        o_scl_oe <= 1'b0;
        do wt(1); while (i_scl !== 1'b1);
        wt(Q);
        r = i_sda;
        wt(Q);
        o_scl_oe <= 1'b1;
        wt(Q);
    endtask
    // sda falls while scl high
    task automatic start;
        o_sda_oe <= 1'b0;
        o_scl_oe <= 1'b0;
        wt(2 * Q);
        o_sda_oe <= 1'b1;
        wt(2 * Q);
        o_scl_oe <= 1'b1;
        wt(Q);
    endtask
    // sda rises while scl high; clock stops after it
    task automatic stop;
        o_sda_oe <= 1'b1;
        wt(Q);
        o_scl_oe <= 1'b0;
        do wt(1); while (i_scl !== 1'b1);
        wt(2 * Q);
        o_sda_oe <= 1'b0;
        wt(2 * Q);
    endtask
    // eight bits msb first, then the acknowledge clock
    task automatic xfer(input logic [7:0] tx, input logic ack_in,
                        output logic [7:0] rx, output logic ack);
        for (int i = 7; i >= 0; i--) bit_x(tx[i], rx[i]);
        bit_x(ack_in, ack);
    endtask
endmodule // tws_master

// ===== testbench/tws_slave_tb.sv
// self-checking bench for the two-wire slave
`timescale 1ns/1ns
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin mismatches++; \
    $display("wrong value at %0t: got %h want %h", $time, (a), (e)); end end
module tws_slave_tb;
    logic        clk, rst_n, psel, penable, pwrite, err, ack;
    logic        pready, pslverr, o_scl, scl_oe, o_sda, sda_oe, irq;
    logic [7:0]  paddr, r8;
    logic [31:0] pwdata, prdata, rd;
    wire logic   m_scl_oe, m_sda_oe;
    int          mismatches, comparisons, cyc, irqs, n;
    // pulled-up wires: low while any party drives
    wire scl = !(m_scl_oe || scl_oe);
    wire sda = !(m_sda_oe || sda_oe);
    tws_slave DUT (
        .I_CORE_CLK(clk), .I_RST_N(rst_n), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(pslverr), .I_SCL(scl), .O_SCL(o_scl),
        .O_SCL_OE(scl_oe), .I_SDA(sda), .O_SDA(o_sda), .O_SDA_OE(sda_oe), .O_IRQ(irq)
    );
    tws_master u_mst (
        .i_clk(clk), .i_scl(scl), .i_sda(sda), .o_scl_oe(m_scl_oe), .o_sda_oe(m_sda_oe)
    );
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // irq pulse count and hang guard
    always @(posedge clk) begin
        if (irq === 1'b1) irqs++;
        cyc++;
        if (cyc == 30000) begin
            mismatches++;
            test_done();
        end
    end
    // ========================================
    // apb master: holds the request until pready is seen
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd8(input logic [7:0] a);
        apb(1'b0, a, 32'h0);
        r8 = rd[7:0];
    endtask
    task automatic test_done;
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // ========================================
    // scenarios
    task automatic t_regs;
        rd8(tws_pkg::ADDR_CTRL1);
        `CHK(rd, 32'h00000080)
        rd8(tws_pkg::ADDR_CTRL0);
        `CHK(rd, 32'h00000000)
        `CHK({o_scl, o_sda}, 2'h0)
        apb(1'b1, tws_pkg::ADDR_OWN, 32'h000000A5);
        rd8(tws_pkg::ADDR_OWN);
        `CHK(rd, 32'h000000A4)
        apb(1'b0, 8'h10, 32'h0);
        `CHK({err, rd}, 33'h100000000)
        $display("test regs done");
    endtask
    task automatic t_off;
        n = irqs;
        u_mst.start();
        u_mst.xfer(8'hA4, 1'b1, r8, ack);
        `CHK(ack, 1'b1)
        u_mst.stop();
        `CHK(irqs, n)
        $display("test off done");
    endtask
    task automatic t_miss;
        apb(1'b1, tws_pkg::ADDR_CTRL0, 32'h0000001D);
        apb(1'b1, tws_pkg::ADDR_CTRL0, 32'h0000005D);
        n = irqs;
        u_mst.start();
        u_mst.xfer(8'hA6, 1'b1, r8, ack);
        `CHK(ack, 1'b1)
        rd8(tws_pkg::ADDR_CTRL1);
        `CHK(r8 & 8'h60, 8'h20)
        u_mst.stop();
        `CHK(irqs, n)
        $display("test mismatch done");
    endtask
    task automatic t_wr;
        apb(1'b1, tws_pkg::ADDR_CTRL0, 32'h0000004D);
        n = irqs;
        u_mst.start();
        u_mst.xfer(8'hA4, 1'b1, r8, ack);
        `CHK(ack, 1'b0)
        `CHK(irqs, n + 1)
        rd8(tws_pkg::ADDR_CTRL1);
        `CHK(r8 & 8'h64, 8'h60)
        rd8(tws_pkg::ADDR_DATA);
        u_mst.xfer(8'h96, 1'b1, r8, ack);
        `CHK(ack, 1'b0)
        repeat (8) @(posedge clk);
        `CHK(irqs, n + 2)
        rd8(tws_pkg::ADDR_CTRL1);
        `CHK(r8 & 8'hC0, 8'h80)
        apb(1'b1, tws_pkg::ADDR_CTRL1, 32'h00000008);
        rd8(tws_pkg::ADDR_DATA);
        `CHK(r8, 8'h96)
        u_mst.xfer(8'h3C, 1'b1, r8, ack);
        `CHK(ack, 1'b1)
        rd8(tws_pkg::ADDR_DATA);
        `CHK(r8, 8'h3C)
        u_mst.stop();
        rd8(tws_pkg::ADDR_CTRL1);
        `CHK(r8 & 8'hA0, 8'h00)
        $display("test write done");
    endtask
    task automatic t_rd;
        apb(1'b1, tws_pkg::ADDR_CTRL0, 32'h0000006D);
        u_mst.start();
        u_mst.xfer(8'hA5, 1'b1, r8, ack);
        `CHK(ack, 1'b0)
        rd8(tws_pkg::ADDR_CTRL1);
        `CHK(r8 & 8'h44, 8'h44)
        apb(1'b1, tws_pkg::ADDR_CTRL1, 32'h00000010);
        apb(1'b1, tws_pkg::ADDR_DATA, 32'h000000C3);
        u_mst.xfer(8'hFF, 1'b0, r8, ack);
        `CHK(r8, 8'hC3)
        repeat (8) @(posedge clk);
        rd8(tws_pkg::ADDR_CTRL1);
        `CHK(r8 & 8'h91, 8'h90)
        apb(1'b1, tws_pkg::ADDR_DATA, 32'h0000005A);
        u_mst.xfer(8'hFF, 1'b1, r8, ack);
        `CHK(r8, 8'h5A)
        rd8(tws_pkg::ADDR_CTRL1);
        `CHK(r8 & 8'h01, 8'h01)
        `CHK(sda, 1'b1)
        u_mst.stop();
        $display("test read done");
    endtask
    // ========================================
    // main sequence
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        rst_n = 1'b0;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        t_regs();
        t_off();
        t_miss();
        t_wr();
        t_rd();
        test_done();
    end
endmodule // tws_slave_tb
